// *** lecr_asserts.sv ***
// checker for the enhancement register bank
// sees only lecr_top ports; bound below
`timescale 1ns/1ps
module lecr_asserts
    import lecr_pkg::*;
#(
    parameter int unsigned MEAS_W = 16
)
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // watched ports
    input wire logic [7:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire lecr_enh_t enh,
    input wire logic release_control_bit,
    input wire logic ring_burst_end,
    input wire logic current_limit_boosted,
    input wire logic tone_tick,
    input wire logic osc_timer_tick,
    input wire logic osc_params_dedicated,
    input wire logic batt_switch_req,
    input wire logic batt_switch_state,
    input wire logic [MEAS_W-1:0] tr_voltage,
    input wire logic [MEAS_W-1:0] loop_current,
    input wire logic [MEAS_W-1:0] closure_upper,
    input wire logic loop_closed
);
    // ****************************************
    // assertions
    // ****************************************
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside read cycle");
    a_cm_rsvd_zero: assert property ($past(reg_rd) && $past(reg_addr) == ADDR_CM_CAL
        |-> reg_rdata[7:6] == 2'h0) else $error("cm result upper bits set");
    a_dcpk_rsvd_zero: assert property ($past(reg_rd) && $past(reg_addr) == ADDR_DCPK_CAL
        |-> reg_rdata[7:4] == 4'h0) else $error("dc peak upper bits set");
    a_enh_read_back: assert property ($past(reg_rd) && $past(reg_addr) == ADDR_ENH
        |-> reg_rdata == $past(enh)) else $error("enable readback differs");
    a_boost_start: assert property ($past(ring_burst_end) && $past(enh.current_limit_boost_en)
        |-> current_limit_boosted) else $error("boost did not start");
    a_dedicated_sel: assert property (osc_params_dedicated ==
        $past(enh.caller_id_tone_enh_en && release_control_bit)) else $error("param select wrong");
    a_timer_tick_twin: assert property (tone_tick == osc_timer_tick)
        else $error("timer tick differs from tone tick");
    a_tick_one_cycle: assert property (tone_tick |=> !tone_tick)
        else $error("tone tick longer than one cycle");
    a_closure_no_hyst: assert property (!$past(enh.loop_closure_hyst_en) |-> loop_closed ==
        ($past(enh.voltage_loop_closure_en) ? $past(tr_voltage) > $past(closure_upper)
        : $past(loop_current) > $past(closure_upper))) else $error("loop closure wrong");
    a_batt_follow: assert property (!$past(enh.battery_switch_debounce_en)
        |-> batt_switch_state == $past(batt_switch_req)) else $error("battery state lags");
endmodule
bind lecr_top lecr_asserts #(.MEAS_W(MEAS_W)) u_chk (
    .core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .enh(enh), .release_control_bit(release_control_bit),
    .ring_burst_end(ring_burst_end), .current_limit_boosted(current_limit_boosted),
    .tone_tick(tone_tick), .osc_timer_tick(osc_timer_tick),
    .osc_params_dedicated(osc_params_dedicated), .batt_switch_req(batt_switch_req),
    .batt_switch_state(batt_switch_state), .tr_voltage(tr_voltage),
    .loop_current(loop_current), .closure_upper(closure_upper), .loop_closed(loop_closed)
);

// *** lecr_pkg.sv ***
// line enhancement configuration register bank: shared constants and types
// assumes an 8-bit register port and a single 125 MHz core clock
package lecr_pkg;

    // ****************************************
    // clock and timing
    // ****************************************
    localparam int unsigned CLK_HZ = 125000000;
    localparam int unsigned TONE_FAST_HZ = 24000;
    localparam int unsigned TONE_SLOW_HZ = 8000;
    localparam int unsigned TONE_FAST_CYC = CLK_HZ / TONE_FAST_HZ;
    localparam int unsigned TONE_SLOW_CYC = CLK_HZ / TONE_SLOW_HZ;
    localparam int unsigned BATTERY_SWITCH_DEBOUNCE_EN_MS = 60;
    localparam int unsigned BATTERY_SWITCH_DEBOUNCE_EN_CYC = BATTERY_SWITCH_DEBOUNCE_EN_MS * (CLK_HZ / 1000);
    localparam int unsigned BOOST_HOLD_CYC = 125000;
    localparam int unsigned TONE_CNT_W = 14;
    localparam int unsigned DEB_CNT_W = 23;
    localparam int unsigned BOOST_CNT_W = 24;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] ADDR_CM_CAL = 8'h6A;
    localparam logic [7:0] ADDR_DCPK_CAL = 8'h6B;
    localparam logic [7:0] ADDR_ENH = 8'h6C;
    localparam logic [5:0] CM_CAL_RST = 6'h00;
    localparam logic [3:0] DCPK_CAL_RST = 4'h8;
    localparam logic [7:0] ENH_RST = 8'h00;
    localparam int unsigned CM_CAL_W = 6;
    localparam int unsigned DCPK_CAL_W = 4;
    localparam int unsigned LIMIT_W = 6;
    localparam logic [5:0] BOOST_LIMIT_MA = 6'h29;

    // enhancement register layout, bit 7 first
    typedef struct packed {
        logic current_limit_boost_en;
        logic caller_id_tone_enh_en;
        logic converter_speedup_en;
        logic ext_impedance_ref_en;
        logic battery_switch_debounce_en;
        logic voltage_loop_closure_en;
        logic converter_squelch_en;
        logic loop_closure_hyst_en;
    } lecr_enh_t;

    // whole state of the bank
    typedef struct packed {
        logic [1:0] rst_sync;
        logic [5:0] cm_bal;
        logic [3:0] dc_peak;
        lecr_enh_t enh;
        logic [7:0] rdata;
        logic [TONE_CNT_W-1:0] tone_cnt;
        logic tone_tick;
        logic dedicated_sel;
        logic [BOOST_CNT_W-1:0] boost_cnt;
        logic boosted;
        logic [5:0] limit;
        logic [DEB_CNT_W-1:0] deb_cnt;
        logic batt_state;
        logic loop_closed;
    } lecr_state_t;

endpackage

// *** lecr_top.sv ***
// line enhancement configuration register bank with its line-control effects
// assumes inputs synchronous to core_clk; analog blocks consume the outputs
`timescale 1ns/1ps
module lecr_top
    import lecr_pkg::*;
#(
    parameter int unsigned MEAS_W = 16,
    parameter int unsigned TONE_FAST_PERIOD = TONE_FAST_CYC,
    parameter int unsigned TONE_SLOW_PERIOD = TONE_SLOW_CYC,
    parameter int unsigned DEBOUNCE_PERIOD = BATTERY_SWITCH_DEBOUNCE_EN_CYC,
    parameter int unsigned BOOST_PERIOD = BOOST_HOLD_CYC
)
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // calibration engine results
    input wire logic cm_cal_load,
    input wire logic [CM_CAL_W-1:0] cm_cal_value,
    input wire logic dcpk_cal_load,
    input wire logic [DCPK_CAL_W-1:0] dcpk_cal_value,
    // line state from the rest of the device
    input wire logic release_control_bit,
    input wire logic [LIMIT_W-1:0] programmed_current_limit,
    input wire logic ring_burst_end,
    input wire logic external_battery_select,
    input wire logic batt_switch_req,
    input wire logic [MEAS_W-1:0] tr_voltage,
    input wire logic [MEAS_W-1:0] loop_current,
    input wire logic [MEAS_W-1:0] closure_upper,
    input wire logic [MEAS_W-1:0] closure_lower,
    // controls to the analog and dsp blocks
    output lecr_enh_t enh,
    output logic [LIMIT_W-1:0] current_limit_ma,
    output logic current_limit_boosted,
    output logic tone_tick,
    output logic osc_timer_tick,
    output logic osc_params_dedicated,
    output logic batt_switch_state,
    output logic loop_closed
);

    // ****************************************
    // state
    // ****************************************
    localparam lecr_state_t STATE_RST = '{
        rst_sync: 2'h0,
        cm_bal: CM_CAL_RST,
        dc_peak: DCPK_CAL_RST,
        enh: lecr_enh_t'(ENH_RST),
        rdata: 8'h00,
        tone_cnt: '0,
        tone_tick: 1'b0,
        dedicated_sel: 1'b0,
        boost_cnt: '0,
        boosted: 1'b0,
        limit: 6'h00,
        deb_cnt: '0,
        batt_state: 1'b0,
        loop_closed: 1'b0
    };

    lecr_state_t s_q;
    lecr_state_t s_d;
    logic [MEAS_W-1:0] meas;
    logic tone_wrap;

    // ****************************************
    // next state
    // ****************************************
    always_comb
    begin
        s_d = s_q;
        meas = '0;
        tone_wrap = 1'b0;
        s_d.rst_sync = {s_q.rst_sync[0], 1'b1};

        // read data stand one cycle after the strobe, zero otherwise
        s_d.rdata = 8'h00;
        if (reg_rd)
        begin
            case (reg_addr)
                ADDR_CM_CAL: s_d.rdata = {2'h0, s_q.cm_bal};
                ADDR_DCPK_CAL: s_d.rdata = {4'h0, s_q.dc_peak};
                ADDR_ENH: s_d.rdata = s_q.enh;
                default: s_d.rdata = 8'h00;
            endcase
        end

        // software writes; unmapped addresses are ignored
        if (reg_wr)
        begin
            case (reg_addr)
                ADDR_CM_CAL: s_d.cm_bal = reg_wdata[5:0];
                ADDR_DCPK_CAL: s_d.dc_peak = reg_wdata[3:0];
                ADDR_ENH: s_d.enh = lecr_enh_t'(reg_wdata);
                default: s_d.enh = s_q.enh;
            endcase
        end

        // a calibration result landing with a write wins over it
        if (cm_cal_load)
        begin
            s_d.cm_bal = cm_cal_value;
        end
        if (dcpk_cal_load)
        begin
            s_d.dc_peak = dcpk_cal_value;
        end

        // ****************************************
        // tone generator clock
        // ****************************************
        s_d.dedicated_sel = s_q.enh.caller_id_tone_enh_en & release_control_bit;
        if (s_q.dedicated_sel)
        begin
            tone_wrap = s_q.tone_cnt >= TONE_CNT_W'(TONE_FAST_PERIOD - 1);
        end
        else
        begin
            tone_wrap = s_q.tone_cnt >= TONE_CNT_W'(TONE_SLOW_PERIOD - 1);
        end
        // >= lets a mode change that shortens the period end at once
        if (tone_wrap)
        begin
            s_d.tone_cnt = '0;
        end
        else
        begin
            s_d.tone_cnt = s_q.tone_cnt + 1'b1;
        end
        s_d.tone_tick = tone_wrap;

        // ****************************************
        // current limit boost
        // ****************************************
        if (!s_q.enh.current_limit_boost_en)
        begin
            s_d.boosted = 1'b0;
            s_d.boost_cnt = '0;
        end
        else if (ring_burst_end)
        begin
            s_d.boosted = 1'b1;
            s_d.boost_cnt = BOOST_CNT_W'(BOOST_PERIOD - 1);
        end
        else if (s_q.boosted)
        begin
            if (s_q.boost_cnt == '0)
            begin
                s_d.boosted = 1'b0;
            end
            else
            begin
                s_d.boost_cnt = s_q.boost_cnt - 1'b1;
            end
        end
        if (s_d.boosted)
        begin
            s_d.limit = BOOST_LIMIT_MA;
        end
        else
        begin
            s_d.limit = programmed_current_limit;
        end

        // ****************************************
        // battery switch debounce
        // ****************************************
        if (s_q.enh.battery_switch_debounce_en && external_battery_select)
        begin
            // a request that bounces back restarts the wait
            if (batt_switch_req == s_q.batt_state)
            begin
                s_d.deb_cnt = '0;
            end
            else if (s_q.deb_cnt == DEB_CNT_W'(DEBOUNCE_PERIOD - 1))
            begin
                s_d.batt_state = batt_switch_req;
                s_d.deb_cnt = '0;
            end
            else
            begin
                s_d.deb_cnt = s_q.deb_cnt + 1'b1;
            end
        end
        else
        begin
            s_d.batt_state = batt_switch_req;
            s_d.deb_cnt = '0;
        end

        // ****************************************
        // loop closure
        // ****************************************
        if (s_q.enh.voltage_loop_closure_en)
        begin
            meas = tr_voltage;
        end
        else
        begin
            meas = loop_current;
        end
        if (s_q.enh.loop_closure_hyst_en && s_q.loop_closed)
        begin
            s_d.loop_closed = meas >= closure_lower;
        end
        else
        begin
            s_d.loop_closed = meas > closure_upper;
        end

        // synchronised reset holds everything but the synchroniser
        if (!s_q.rst_sync[1])
        begin
            s_d = STATE_RST;
            s_d.rst_sync = {s_q.rst_sync[0], 1'b1};
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s_q <= STATE_RST;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ****************************************
    // outputs, all straight from flops
    // ****************************************
    assign reg_rdata = s_q.rdata;
    assign enh = s_q.enh;
    assign current_limit_ma = s_q.limit;
    assign current_limit_boosted = s_q.boosted;
    assign tone_tick = s_q.tone_tick;
    // timers share the tone tick, so they step 41.67 us in fast mode
    assign osc_timer_tick = s_q.tone_tick;
    assign osc_params_dedicated = s_q.dedicated_sel;
    assign batt_switch_state = s_q.batt_state;
    assign loop_closed = s_q.loop_closed;

endmodule

// *** line_enhancement_config_regs_bench.sv ***
// bench for the enhancement register bank
// drives every lecr_top input itself; short counts
`timescale 1ns/1ps
module line_enhancement_config_regs_bench;
    import lecr_pkg::*;
    // ****************************************
    // stimulus and dut
    // ****************************************
    logic core_clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, cm_cal_load = 0, dcpk_cal_load = 0;
    logic release_control_bit = 0, ring_burst_end = 0, external_battery_select = 0;
    logic batt_switch_req = 0, current_limit_boosted, tone_tick, osc_timer_tick;
    logic osc_params_dedicated, batt_switch_state, loop_closed;
    logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata;
    logic [5:0] cm_cal_value = 0, programmed_current_limit = 6'h14, current_limit_ma;
    logic [3:0] dcpk_cal_value = 0;
    logic [15:0] tr_voltage = 0, loop_current = 0, closure_upper = 16'h0064;
    logic [15:0] closure_lower = 16'h0032;
    logic [15:0] tv [4] = '{16'h0078, 16'h0046, 16'h0028, 16'h0046};
    lecr_enh_t enh;
    int error_cnt = 0, checks = 0, cyc = 0, n, i;
    always #4 core_clk = ~core_clk;
    // short counts keep the run brief
    lecr_top #(.TONE_FAST_PERIOD(6), .TONE_SLOW_PERIOD(18), .DEBOUNCE_PERIOD(20),
        .BOOST_PERIOD(10)) DUT (
        .core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cm_cal_load(cm_cal_load),
        .cm_cal_value(cm_cal_value), .dcpk_cal_load(dcpk_cal_load),
        .dcpk_cal_value(dcpk_cal_value), .release_control_bit(release_control_bit),
        .programmed_current_limit(programmed_current_limit),
        .ring_burst_end(ring_burst_end), .external_battery_select(external_battery_select),
        .batt_switch_req(batt_switch_req), .tr_voltage(tr_voltage),
        .loop_current(loop_current), .closure_upper(closure_upper),
        .closure_lower(closure_lower), .enh(enh), .current_limit_ma(current_limit_ma),
        .current_limit_boosted(current_limit_boosted), .tone_tick(tone_tick),
        .osc_timer_tick(osc_timer_tick), .osc_params_dedicated(osc_params_dedicated),
        .batt_switch_state(batt_switch_state), .loop_closed(loop_closed)
    );
    // ****************************************
    // tasks
    // ****************************************
    task step; begin @(posedge core_clk); #1; end endtask
    task chk(input string s, input logic [15:0] e, input logic [15:0] g);
        begin
            checks++;
            if (g !== e)
            begin
                error_cnt++;
                $display("[FAIL] %s expected %h seen %h", s, e, g);
            end
        end
    endtask
    // one edge passes after each strobe so back to back calls never collide
    task wr(input logic [7:0] a, input logic [7:0] d);
        begin
            reg_addr <= a;
            reg_wdata <= d;
            reg_wr <= 1;
            step;
            reg_wr <= 0;
            step;
        end
    endtask
    // read data stand only in the cycle right after the strobe
    task rd(input logic [7:0] a, input logic [7:0] e);
        begin
            reg_addr <= a;
            reg_rd <= 1;
            step;
            reg_rd <= 0;
            chk("rdata", e, reg_rdata);
            step;
        end
    endtask
    // waits for a tick, then counts cycles to the next one
    task per(output int k);
        begin
            k = 0;
            while (tone_tick !== 1'b1 && k < 100) begin step; k++; end
            k = 0;
            do begin step; k++; end while (tone_tick !== 1'b1 && k < 100);
        end
    endtask
    task test_done;
        begin
            if (error_cnt == 0 && checks > 0) $display("ALL CHECKS OK");
            else $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            error_cnt++;
            test_done;
        end
    end
    // ****************************************
    // tests
    // ****************************************
    initial
    begin
        repeat (8) @(posedge core_clk);
        rst_b <= 1;
        repeat (3) step;
        rd(ADDR_CM_CAL, 8'h00);
        rd(ADDR_DCPK_CAL, 8'h08);
        rd(ADDR_ENH, ENH_RST);
        wr(ADDR_DCPK_CAL, 8'hFF);
        rd(ADDR_DCPK_CAL, 8'h0F);
        wr(8'h6D, 8'hFF);
        rd(8'h6D, 8'h00);
        wr(ADDR_CM_CAL, 8'hFF);
        rd(ADDR_CM_CAL, 8'h3F);
        // a calibration load in the same cycle as a software write wins
        cm_cal_value <= 6'h2A; cm_cal_load <= 1; dcpk_cal_value <= 4'h3; dcpk_cal_load <= 1;
        reg_addr <= ADDR_CM_CAL;
        reg_wdata <= 8'h15;
        reg_wr <= 1;
        step;
        cm_cal_load <= 0;
        dcpk_cal_load <= 0;
        reg_wr <= 0;
        step;
        rd(ADDR_CM_CAL, 8'h2A);
        rd(ADDR_DCPK_CAL, 8'h03);
        for (i = 0; i < 8; i++)
        begin
            wr(ADDR_ENH, 8'h01 << i);
            chk("enh", 8'h01 << i, enh);
            rd(ADDR_ENH, 8'h01 << i);
        end
        // boost raises the limit to 41 mA, then falls back
        wr(ADDR_ENH, 8'h80); ring_burst_end <= 1; step; ring_burst_end <= 0; step;
        chk("limit", BOOST_LIMIT_MA, current_limit_ma);
        chk("boosted", 1, current_limit_boosted);
        // the raised limit holds for exactly the boost period of 10 cycles
        repeat (8) step;
        chk("limit", BOOST_LIMIT_MA, current_limit_ma);
        step;
        chk("limit", 6'h14, current_limit_ma);
        chk("boosted", 0, current_limit_boosted);
        for (i = 0; i < 3; i++)
        begin
            release_control_bit <= (i != 2);
            wr(ADDR_ENH, i == 1 ? 8'h00 : 8'h40);
            per(n); per(n);
            chk("tone", i == 0 ? 6 : 18, n);
            chk("dedicated", i == 0, osc_params_dedicated);
        end
        wr(ADDR_ENH, 8'h08); external_battery_select <= 1; batt_switch_req <= 1;
        n = 0;
        while (batt_switch_state !== 1'b1 && n < 40) begin step; n++; end
        chk("debounce", 20, n);
        wr(ADDR_ENH, 8'h00); batt_switch_req <= 0; step;
        chk("batt", 0, batt_switch_state);
        loop_current <= 16'h00C8; step; step;
        chk("closed", 1, loop_closed);
        loop_current <= 0;
        wr(ADDR_ENH, 8'h05);
        for (i = 0; i < 4; i++)
        begin
            tr_voltage <= tv[i]; step; step;
            chk("closed", i < 2, loop_closed);
        end
        // a reset in mid-run brings the registers back to their reset values
        rst_b <= 0;
        step;
        rst_b <= 1;
        repeat (3) step;
        rd(ADDR_ENH, ENH_RST);
        rd(ADDR_DCPK_CAL, 8'h08);
        test_done;
    end
endmodule
